// ---- bench/ctx_counter_transfer_assertions.sv ----
/*
 * Bus and command timing assertions for the counter transfer block.
 * Assumes it is bound to ctx_counter_transfer and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ctx_regs.svh"

module ctx_counter_transfer_checker #(
	parameter int LINKS       = 16,
	parameter int KINDS       = 12,
	parameter int CNT_W       = 32,
	parameter int LATCH_EDGES = 8000
) (
	input wire logic                   clk,
	input wire logic                   rst_n,
	input wire logic                   cyc_i,
	input wire logic                   stb_i,
	input wire logic                   we_i,
	input wire logic [13:0]            adr_i,
	input wire logic [3:0]             sel_i,
	input wire logic [31:0]            dat_i,
	input wire logic [31:0]            dat_o,
	input wire logic                   ack_o,
	input wire logic                   external_snapshot_strobe,
	input wire logic [LINKS*KINDS-1:0] countEvent,
	input wire logic [LINKS-1:0]       rxFifoOverflow,
	input wire logic [LINKS-1:0]       linkOutsideGroup,
	input wire logic                   transferPending
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	logic [11:0] idx;
	logic        take;
	logic        rdTake;
	logic        cmdWr;
	logic        isStat;
	logic        mapped;
	assign idx    = adr_i[13:2];
	assign take   = cyc_i && stb_i && !ack_o;
	assign rdTake = take && !we_i;
	// a command write landing in the execute cycle is ignored by design
	assign cmdWr  = cyc_i && stb_i && ack_o && we_i && sel_i[0] && idx == `CTX_IDX_CMD
		&& !transferPending;
	assign isStat = idx >= `CTX_IDX_STAT_BASE && idx <= `CTX_IDX_STAT_LAST;
	assign mapped = idx == `CTX_IDX_CMD || isStat
		|| (idx >= `CTX_IDX_DATA_UP && idx <= `CTX_IDX_SELECT);

	// ------------------------------------------------
	// bus handshake, command execution and read data
	// ------------------------------------------------
	sequence cmdTaken;
		cmdWr;
	endsequence
	sequence execOnce;
		transferPending ##1 !transferPending;
	endsequence

	chk_ack_follows: assert property (take |=> ack_o)
		else $error("no ack after a taken request");
	chk_ack_single: assert property (ack_o |=> !ack_o)
		else $error("ack longer than one cycle");
	chk_ack_cause: assert property (ack_o |-> $past(take))
		else $error("ack without request");
	chk_cmd_exec: assert property (cmdTaken |-> ##[1:2] execOnce)
		else $error("command did not execute once");
	chk_exec_cause: assert property ($rose(transferPending) |-> $past(cmdWr) || $past(cmdWr, 2))
		else $error("execute without command");
	chk_unmapped_zero: assert property (rdTake && !mapped |=> dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	chk_stat_high_zero: assert property (rdTake && isStat |=> dat_o[31:13] == 19'h0_0000)
		else $error("status unused bits not zero");
	chk_data_high_zero: assert property (rdTake && idx == `CTX_IDX_DATA_UP |=> dat_o[31:8] == 24'h00_0000)
		else $error("upper byte register high bits not zero");
endmodule : ctx_counter_transfer_checker

bind ctx_counter_transfer ctx_counter_transfer_checker #(
	.LINKS(LINKS), .KINDS(KINDS), .CNT_W(CNT_W), .LATCH_EDGES(LATCH_EDGES)
) ctx_checker_inst (
	.clk(clk), .rst_n(rst_n), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
	.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
	.external_snapshot_strobe(external_snapshot_strobe), .countEvent(countEvent),
	.rxFifoOverflow(rxFifoOverflow), .linkOutsideGroup(linkOutsideGroup),
	.transferPending(transferPending)
);
`default_nettype wire

// ---- bench/testbench.sv ----
/*
 * Self-checking bench for the counter transfer block.
 * Assumes a short snapshot divider so divided latching is reached quickly.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ctx_regs.svh"

module testbench;
	localparam int EDGES = 4;
	typedef struct packed {
		logic        w;
		logic [11:0] idx;
		logic [15:0] d;
		logic [15:0] mask;
		logic [15:0] exp;
	} ctx_row_t;

	logic         clk = 1'b0;
	logic         rst_n = 1'b0;
	logic         cyc = 1'b0;
	logic         stb = 1'b0;
	logic         we = 1'b0;
	logic [13:0]  adr = 14'h0000;
	logic [3:0]   sel = 4'h0;
	logic [31:0]  datI = 32'h0000_0000;
	logic [31:0]  datO;
	logic         ack;
	logic         strobe = 1'b0;
	logic [191:0] ev = '0;
	logic [15:0]  fifo = 16'h0000;
	logic [15:0]  outGrp = 16'h0000;
	logic         pend;
	logic [31:0]  rd;
	logic [31:0]  ctr;
	int           nErrors = 0;
	int           numChecks = 0;

	// bit 5 of the command reads undefined, so it is masked out
	localparam ctx_row_t ROWS [18] = '{
		'{1'b0, `CTX_IDX_CMD, 16'h0000, 16'hFFDF, 16'h0080},
		'{1'b0, `CTX_IDX_STAT_BASE, 16'h0000, 16'hFFFF, 16'h0000},
		'{1'b0, `CTX_IDX_STAT_LAST, 16'h0000, 16'hFFFF, 16'h0000},
		'{1'b0, 12'h0500, 16'h0000, 16'hFFFF, 16'h0000},
		'{1'b1, `CTX_IDX_SELECT, 16'h0005, 16'h0000, 16'h0000},
		'{1'b1, `CTX_IDX_DATA_UP, 16'h0012, 16'h0000, 16'h0000},
		'{1'b1, `CTX_IDX_DATA_MID, 16'h3456, 16'h0000, 16'h0000},
		'{1'b1, `CTX_IDX_DATA_LOW, 16'h0078, 16'h0000, 16'h0000},
		'{1'b1, `CTX_IDX_CMD, 16'h0001, 16'h0000, 16'h0000},
		'{1'b1, `CTX_IDX_DATA_UP, 16'h0000, 16'h0000, 16'h0000},
		'{1'b1, `CTX_IDX_DATA_MID, 16'h0000, 16'h0000, 16'h0000},
		'{1'b1, `CTX_IDX_DATA_LOW, 16'h0000, 16'h0000, 16'h0000},
		'{1'b1, `CTX_IDX_CMD, 16'h0005, 16'h0000, 16'h0000},
		'{1'b0, `CTX_IDX_DATA_UP, 16'h0000, 16'hFFFF, 16'h0012},
		'{1'b0, `CTX_IDX_DATA_MID, 16'h0000, 16'hFFFF, 16'h3456},
		'{1'b0, `CTX_IDX_DATA_LOW, 16'h0000, 16'hFFFF, 16'h0078},
		'{1'b0, `CTX_IDX_SELECT, 16'h0000, 16'h00FF, 16'h0005},
		'{1'b0, `CTX_IDX_CMD, 16'h0000, 16'h0080, 16'h0080}
	};

	ctx_counter_transfer #(.LATCH_EDGES(EDGES)) ctx_counter_transfer_inst (
		.clk(clk), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
		.sel_i(sel), .dat_i(datI), .dat_o(datO), .ack_o(ack),
		.external_snapshot_strobe(strobe), .countEvent(ev), .rxFifoOverflow(fifo),
		.linkOutsideGroup(outGrp), .transferPending(pend)
	);

	initial begin
		forever #25 clk = ~clk;
	end

	// ------------------------------------------------
	// bus and check helpers
	// ------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		numChecks++;
		if (seen !== exp) begin
			nErrors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic giveVerdict();
		$display("checks %0d errors %0d", numChecks, nErrors);
		if (nErrors == 0 && numChecks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : giveVerdict

	// entered just after a rising edge; read data is taken at the ack edge
	task automatic bus(input logic w, input logic [11:0] idx, input logic [15:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {idx, 2'b00};
		sel <= 4'h3;
		datI <= {16'h0000, d};
		do @(posedge clk); while (ack !== 1'b1);
		rd = datO;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask : bus

	task automatic rdChk(input logic [11:0] idx, input logic [15:0] exp);
		bus(1'b0, idx, 16'h0000);
		check(rd, {16'h0000, exp});
	endtask : rdChk

	task automatic cmd(input logic [15:0] c);
		bus(1'b1, `CTX_IDX_CMD, c); // callers keep bits 11, 5 and 4 at zero
		do bus(1'b0, `CTX_IDX_CMD, 16'h0000); while (rd[7] !== 1'b1);
	endtask : cmd

	task automatic loadCtr(input logic [7:0] i, input logic [31:0] v);
		bus(1'b1, `CTX_IDX_SELECT, {8'h00, i});
		bus(1'b1, `CTX_IDX_DATA_UP, {8'h00, v[31:24]});
		bus(1'b1, `CTX_IDX_DATA_MID, v[23:8]);
		bus(1'b1, `CTX_IDX_DATA_LOW, {8'h00, v[7:0]});
		cmd(16'h0001);
	endtask : loadCtr

	task automatic readCtr(input logic [15:0] hi, input logic [31:0] exp);
		cmd(hi | 16'h0005);
		bus(1'b0, `CTX_IDX_DATA_UP, 16'h0000);
		ctr[31:24] = rd[7:0];
		bus(1'b0, `CTX_IDX_DATA_MID, 16'h0000);
		ctr[23:8] = rd[15:0];
		bus(1'b0, `CTX_IDX_DATA_LOW, 16'h0000);
		ctr[7:0] = rd[7:0];
		check(ctr, exp);
	endtask : readCtr

	task automatic pulse(input logic [191:0] v, input logic [15:0] f);
		ev <= v;
		fifo <= f;
		@(posedge clk);
		ev <= '0;
		fifo <= 16'h0000;
		repeat (3) @(posedge clk);
	endtask : pulse

	task automatic strobes(input int n);
		repeat (n) begin
			strobe <= 1'b1;
			@(posedge clk);
			strobe <= 1'b0;
			@(posedge clk);
		end
		repeat (2) @(posedge clk);
	endtask : strobes

	initial begin
		repeat (20000) @(posedge clk);
		nErrors++;
		giveVerdict();
	end

	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		foreach (ROWS[i]) begin
			if (ROWS[i].w && ROWS[i].idx == `CTX_IDX_CMD)
				cmd(ROWS[i].d);
			else
				bus(ROWS[i].w, ROWS[i].idx, ROWS[i].d);
			if (!ROWS[i].w)
				check(rd & {16'hFFFF, ROWS[i].mask}, {16'h0000, ROWS[i].exp});
		end
		// link 0 outside any group, link 1 grouped: bits 12..8 must stay clear there
		outGrp <= 16'h0001;
		for (int k = 0; k < 24; k++)
			loadCtr(k[7:0], 32'hFFFF_FFFF);
		pulse({168'h0, 24'hFF_FFFF}, 16'h0003);
		rdChk(`CTX_IDX_STAT_BASE, 16'h1FFF);
		rdChk(`CTX_IDX_STAT_BASE + 12'h001, 16'h00FF);
		bus(1'b1, `CTX_IDX_STAT_BASE, 16'hFFFF);
		rdChk(`CTX_IDX_STAT_BASE, 16'h1FFF);
		bus(1'b1, `CTX_IDX_STAT_BASE, 16'h0FF0);
		rdChk(`CTX_IDX_STAT_BASE, 16'h0FF0);
		loadCtr(8'd30, 32'h0000_1234);
		cmd(16'h0000);
		readCtr(16'h0000, 32'h0000_0000);
		cmd(16'h0002);
		cmd(16'h0006);
		rdChk(`CTX_IDX_DATA_LOW, 16'h0000);
		cmd(16'h000A);
		cmd(16'h0006);
		rdChk(`CTX_IDX_DATA_LOW, 16'h0001);
		bus(1'b0, `CTX_IDX_CMD, 16'h0000);
		ctr = rd;
		bus(1'b1, 12'h0500, 16'hFFFF);
		rdChk(12'h0500, 16'h0000);
		bus(1'b0, `CTX_IDX_CMD, 16'h0000);
		check({31'h0, rd[6]}, {31'h0, !ctr[6]});
		// mid-run reset gives the snapshot divider a known phase
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rdChk(`CTX_IDX_CMD, 16'h0080);
		loadCtr(8'd3, 32'h0000_000A);
		cmd(16'h0205);
		strobes(EDGES - 1);
		readCtr(16'h0200, 32'h0000_0000);
		strobes(1);
		readCtr(16'h0200, 32'h0000_000A);
		pulse(192'h8, 16'h0000);
		readCtr(16'h0100, 32'h0000_000A);
		strobes(1);
		readCtr(16'h0100, 32'h0000_000B);
		pulse(192'h8, 16'h0000);
		readCtr(16'h0100, 32'h0000_000B);
		cmd(16'h0705);
		pulse(192'h8, 16'h0000);
		readCtr(16'h0700, 32'h0000_000C);
		readCtr(16'h0300, 32'h0000_000C);
		readCtr(16'h0000, 32'h0000_000D);
		giveVerdict();
	end
endmodule : testbench
`default_nettype wire

// ---- src/ctx_counter_bank.sv ----
/*
 * Statistics counters with live and snapshot copies and per-counter enables.
 * Assumes increment pulses are one cycle wide and synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none

module ctx_counter_bank #(
	parameter int NUM = 192,
	parameter int W   = 32
) (
	input  wire logic                  clk,
	input  wire logic                  rst_n,
	input  wire logic [NUM-1:0]        incr,
	input  wire logic                  latch,
	input  wire logic                  useSnap,
	input  wire ctx_pkg::ctx_bank_req_t req,
	output logic [W-1:0]               rdValue,
	output logic                       rdEnable,
	output logic [NUM-1:0]             ovf
);

	logic [W-1:0] live [NUM];
	logic [W-1:0] snap [NUM];
	logic [NUM-1:0] enable;

	for (genvar i = 0; i < NUM; i++) begin : g_cnt
		logic hit;
		assign hit = (req.idx == 8'(i));

		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				live[i] <= '0;
			end else if (req.clearAll) begin
				live[i] <= '0;
			end else if (req.wrValue && hit) begin
				live[i] <= req.data[W-1:0];
			end else if (incr[i]) begin
				live[i] <= live[i] + 1'b1;
			end
		end

		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				snap[i] <= '0;
			end else if (req.clearAll) begin
				snap[i] <= '0;
			end else if (latch) begin
				snap[i] <= live[i];
			end
		end

		// enabled by default so overflow reporting works without setup
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				enable[i] <= 1'b1;
			end else if (req.wrEnable && hit) begin
				enable[i] <= req.enVal;
			end
		end

		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				ovf[i] <= 1'b0;
			end else begin
				ovf[i] <= incr[i] && enable[i] && (&live[i]) &&
					!req.clearAll && !(req.wrValue && hit);
			end
		end
	end

	always_comb begin
		rdValue  = '0;
		rdEnable = 1'b0;
		if (req.idx < 8'(NUM)) begin
			rdValue  = useSnap ? snap[req.idx] : live[req.idx];
			rdEnable = enable[req.idx];
		end
	end

endmodule : ctx_counter_bank
`default_nettype wire

// ---- src/ctx_counter_transfer.sv ----
/*
 * Counter transfer command, counter data holding registers and per-link
 * overflow status, reached over a classic Wishbone slave.
 * Assumes link-side event pulses arrive synchronous to clk and that the
 * link clocks feeding those events run while status is accessed.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ctx_regs.svh"

module ctx_counter_transfer #(
	parameter int LINKS       = 16,
	parameter int KINDS       = 12,
	parameter int CNT_W       = 32,
	parameter int LATCH_EDGES = `CTX_EDGES_PER_LATCH
) (
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	// wishbone slave
	input  wire logic                   cyc_i,
	input  wire logic                   stb_i,
	input  wire logic                   we_i,
	input  wire logic [13:0]            adr_i,
	input  wire logic [3:0]             sel_i,
	input  wire logic [31:0]            dat_i,
	output logic [31:0]                 dat_o,
	output logic                        ack_o,
	// link side
	input  wire logic                   external_snapshot_strobe,
	input  wire logic [LINKS*KINDS-1:0] countEvent,
	input  wire logic [LINKS-1:0]       rxFifoOverflow,
	input  wire logic [LINKS-1:0]       linkOutsideGroup,
	output logic                        transferPending
);

	localparam int NUM = LINKS * KINDS;

	logic [15:0]          cmd;
	logic [LINKS-1:0][15:0] stat;
	logic [31:0]          xferData;
	logic [7:0]           counterSelect;
	ctx_pkg::ctx_state_t  state;
	ctx_pkg::ctx_bank_req_t bankReq;
	logic [CNT_W-1:0]     rdValue;
	logic                 rdEnable;
	logic [NUM-1:0]       ovf;
	logic                 latchPulse;
	logic                 swLatch;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic        req;
	logic        wrStb;
	logic [11:0] idx;
	logic [15:0] wd;
	logic [15:0] wmask;
	logic        hitCmd;
	logic        hitStat;
	logic [3:0]  statSel;
	logic        cmdWrite;

	assign req      = cyc_i && stb_i && !ack_o;
	// a write lands at the edge that samples ack high, while the master still holds it
	assign wrStb    = cyc_i && stb_i && we_i && ack_o;
	assign idx      = adr_i[13:2];
	assign wd       = dat_i[15:0];
	assign wmask    = {{8{sel_i[1]}}, {8{sel_i[0]}}};
	assign hitCmd   = (idx == `CTX_IDX_CMD);
	assign hitStat  = (idx >= `CTX_IDX_STAT_BASE) && (idx <= `CTX_IDX_STAT_LAST);
	assign statSel  = idx[3:0];
	// a command arriving during the one-cycle execution is dropped
	assign cmdWrite = wrStb && hitCmd && (state == ctx_pkg::CTX_IDLE);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= req;
		end
	end

	// ----------------------------------------------------------------
	// command register
	// ----------------------------------------------------------------
	logic [15:0] newCmd;
	assign newCmd  = (cmd & ~wmask) | (wd & wmask);
	assign swLatch = cmdWrite && sel_i[1] &&
		(newCmd[`CTX_CMD_MODE_HI:`CTX_CMD_MODE_LO] == `CTX_MODE_SW) &&
		!cmd[`CTX_CMD_SWLATCH] && newCmd[`CTX_CMD_SWLATCH];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cmd <= `CTX_CMD_RESET;
		end else begin
			if (cmdWrite) begin
				cmd <= (newCmd & `CTX_CMD_WMASK) | (cmd & ~`CTX_CMD_WMASK);
			end
			if (wrStb) begin
				cmd[`CTX_CMD_TOGGLE] <= ~cmd[`CTX_CMD_TOGGLE];
			end
			if (cmdWrite && sel_i[0]) begin
				cmd[`CTX_CMD_DONE] <= 1'b0;
			end else if (state == ctx_pkg::CTX_EXEC) begin
				cmd[`CTX_CMD_DONE] <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// transfer engine
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ctx_pkg::CTX_IDLE;
		end else begin
			case (state)
				ctx_pkg::CTX_IDLE: begin
					if (cmdWrite && sel_i[0]) begin
						state <= ctx_pkg::CTX_EXEC;
					end
				end
				ctx_pkg::CTX_EXEC: state <= ctx_pkg::CTX_IDLE;
				default:           state <= ctx_pkg::CTX_IDLE;
			endcase
		end
	end

	assign transferPending = (state == ctx_pkg::CTX_EXEC);

	logic [1:0] op;
	logic       dirToHost;
	assign op        = cmd[1:0];
	assign dirToHost = cmd[`CTX_CMD_DIR];

	always_comb begin
		bankReq          = '0;
		bankReq.idx      = counterSelect;
		bankReq.data     = xferData;
		bankReq.enVal    = cmd[`CTX_CMD_ENVAL];
		if (state == ctx_pkg::CTX_EXEC) begin
			bankReq.clearAll = (op == `CTX_OP_CLEAR);
			bankReq.wrValue  = (op == `CTX_OP_VALUE) && !dirToHost;
			bankReq.wrEnable = (op == `CTX_OP_ENABLE) && !dirToHost;
		end
	end

	// ----------------------------------------------------------------
	// counter data holding register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			xferData <= 32'h0000_0000;
		end else if (state == ctx_pkg::CTX_EXEC && dirToHost &&
				op == `CTX_OP_VALUE) begin
			xferData <= 32'(rdValue);
		end else if (state == ctx_pkg::CTX_EXEC && dirToHost &&
				op == `CTX_OP_ENABLE) begin
			xferData <= {31'h0000_0000, rdEnable};
		end else if (wrStb) begin
			if (idx == `CTX_IDX_DATA_UP && sel_i[0]) begin
				xferData[31:24] <= wd[7:0];
			end
			if (idx == `CTX_IDX_DATA_MID) begin
				if (sel_i[1]) begin
					xferData[23:16] <= wd[15:8];
				end
				if (sel_i[0]) begin
					xferData[15:8] <= wd[7:0];
				end
			end
			if (idx == `CTX_IDX_DATA_LOW && sel_i[0]) begin
				xferData[7:0] <= wd[7:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			counterSelect <= 8'h00;
		end else if (wrStb && idx == `CTX_IDX_SELECT && sel_i[0]) begin
			counterSelect <= wd[7:0];
		end
	end

	// ----------------------------------------------------------------
	// per-link overflow status
	// ----------------------------------------------------------------
	for (genvar l = 0; l < LINKS; l++) begin : g_link
		logic [15:0] setBits;
		logic [15:0] clrBits;
		logic [KINDS-1:0] kindOvf;

		assign kindOvf = ovf[l*KINDS +: KINDS];

		always_comb begin
			setBits = 16'h0000;
			setBits[7:0]  = kindOvf[7:0];
			setBits[11:8] = kindOvf[11:8] & {4{linkOutsideGroup[l]}};
			setBits[`CTX_STAT_FIFO] = rxFifoOverflow[l] && linkOutsideGroup[l];
			clrBits = 16'h0000;
			if (wrStb && hitStat && statSel == 4'(l)) begin
				clrBits = ~wd & wmask & 16'h1FFF;
			end
		end

		// set beats clear in the same cycle so no event is lost
		always_ff @(posedge clk or negedge rst_n) begin
			if (!rst_n) begin
				stat[l] <= `CTX_STAT_RESET;
			end else begin
				stat[l] <= (stat[l] & ~clrBits) | setBits;
			end
		end
	end

	// ----------------------------------------------------------------
	// read data
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dat_o <= 32'h0000_0000;
		end else if (req && !we_i) begin
			dat_o <= 32'h0000_0000;
			if (hitCmd) begin
				dat_o[15:0] <= cmd;
			end else if (hitStat) begin
				dat_o[15:0] <= stat[statSel];
			end else if (idx == `CTX_IDX_DATA_UP) begin
				dat_o[7:0] <= xferData[31:24];
			end else if (idx == `CTX_IDX_DATA_MID) begin
				dat_o[15:0] <= xferData[23:8];
			end else if (idx == `CTX_IDX_DATA_LOW) begin
				dat_o[7:0] <= xferData[7:0];
			end else if (idx == `CTX_IDX_SELECT) begin
				dat_o[7:0] <= counterSelect;
			end
		end
	end

	// ----------------------------------------------------------------
	// leaves
	// ----------------------------------------------------------------
	ctx_latch_timer #(
		.EDGES (LATCH_EDGES)
	) u_latch (
		.clk                      (clk),
		.rst_n                    (rst_n),
		.latchMode                (cmd[`CTX_CMD_MODE_HI:`CTX_CMD_MODE_LO]),
		.swLatch                  (swLatch),
		.external_snapshot_strobe (external_snapshot_strobe),
		.latchPulse               (latchPulse)
	);

	ctx_counter_bank #(
		.NUM (NUM),
		.W   (CNT_W)
	) u_bank (
		.clk      (clk),
		.rst_n    (rst_n),
		.incr     (countEvent),
		.latch    (latchPulse),
		.useSnap  (cmd[`CTX_CMD_MODE_HI:`CTX_CMD_MODE_LO] != `CTX_MODE_OFF),
		.req      (bankReq),
		.rdValue  (rdValue),
		.rdEnable (rdEnable),
		.ovf      (ovf)
	);

endmodule : ctx_counter_transfer
`default_nettype wire

// ---- src/ctx_latch_timer.sv ----
/*
 * Produces the one-cycle snapshot command for the counter bank.
 * Assumes the snapshot strobe pin is synchronous to clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ctx_regs.svh"

module ctx_latch_timer #(
	parameter int EDGES = `CTX_EDGES_PER_LATCH
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic [1:0] latchMode,
	input  wire logic       swLatch,
	input  wire logic       external_snapshot_strobe,
	output logic            latchPulse
);

	logic        strobePrev;
	logic [13:0] edgeCount;
	logic        rise;

	assign rise = external_snapshot_strobe & ~strobePrev;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			strobePrev <= 1'b0;
		end else begin
			strobePrev <= external_snapshot_strobe;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			edgeCount <= 14'h0000;
		end else if (latchMode != `CTX_MODE_DIV) begin
			edgeCount <= 14'h0000;
		end else if (rise) begin
			if (edgeCount == 14'(EDGES - 1)) begin
				edgeCount <= 14'h0000;
			end else begin
				edgeCount <= edgeCount + 14'h0001;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			latchPulse <= 1'b0;
		end else begin
			// the write that enters mode 11 may raise the latch bit while latchMode
			// still shows the old mode, so the software latch is honoured in every mode
			case (latchMode)
				`CTX_MODE_OFF:  latchPulse <= swLatch;
				`CTX_MODE_EDGE: latchPulse <= rise || swLatch;
				`CTX_MODE_DIV:  latchPulse <= swLatch || (rise &&
					(edgeCount == 14'(EDGES - 1)));
				default:        latchPulse <= swLatch;
			endcase
		end
	end

endmodule : ctx_latch_timer
`default_nettype wire

// ---- src/ctx_pkg.sv ----
/*
 * Types shared by the counter transfer block and its leaves.
 * Assumes ctx_regs.svh is compiled alongside for numeric constants.
 */
package ctx_pkg;

	typedef enum logic [1:0] {
		CTX_IDLE,
		CTX_EXEC
	} ctx_state_t;

	// one access from the command engine into the counter bank
	typedef struct packed {
		logic        clearAll;
		logic        wrValue;
		logic        wrEnable;
		logic [7:0]  idx;
		logic [31:0] data;
		logic        enVal;
	} ctx_bank_req_t;

endpackage : ctx_pkg

// ---- src/ctx_regs.svh ----
/*
 * Register map, field positions, reset values and timing counts of the
 * counter transfer and overflow status block.
 * Assumes a 16-bit register model carried on a 32-bit classic Wishbone bus;
 * byte address of a register is four times its index.
 */
// Function
// - latch mode 11: rising change of software latch bit latches; writing 0 does nothing
// - latch mode 00: normal operation, no latching of counter values
// - latch mode 01: latch on every rising edge of the snapshot strobe pin
// - latch mode 10: latch once per 8000 rising edges of snapshot strobe pin
// - command bit 7 reads 1 when transfer is done, 0 while pending
// - command bit 6 inverts on every write access to the block
// - bit 3 is the interrupt enable value moved when operation is 10
// - bit 2 direction: 0 host into counter, 1 counter to host
// - operation 00 clears every statistics counter to zero
// - operation 01 reads or writes the selected counter value
// - operation 10 moves the selected counter's enable bit; 11 unused
// - status bit 12 sets on receive fifo overflow of a non-group link
// - status bits 11..8 set on input-port counter overflow, non-group link only
// - status bits 7..4 set on transmit link counter overflow
// - status bits 3..1 set on receive link counter overflow
// - status bit 0 sets on bad control-protocol cell counter overflow
// - data registers return selected counter bytes and hold write value
`ifndef CTX_REGS_SVH
`define CTX_REGS_SVH

// register indices; byte address is index times four
`define CTX_IDX_CMD        12'h040F
`define CTX_IDX_STAT_BASE  12'h0410
`define CTX_IDX_STAT_LAST  12'h041F
`define CTX_IDX_DATA_UP    12'h0430
`define CTX_IDX_DATA_MID   12'h0431
`define CTX_IDX_DATA_LOW   12'h0432
`define CTX_IDX_SELECT     12'h0433

`define CTX_CMD_RESET      16'h0080
`define CTX_STAT_RESET     16'h0000
`define CTX_CMD_WMASK      16'h0F3F

// command fields
`define CTX_CMD_SWLATCH    10
`define CTX_CMD_MODE_HI    9
`define CTX_CMD_MODE_LO    8
`define CTX_CMD_DONE       7
`define CTX_CMD_TOGGLE     6
`define CTX_CMD_ENVAL      3
`define CTX_CMD_DIR        2

// latch modes and operation codes
`define CTX_MODE_OFF       2'b00
`define CTX_MODE_EDGE      2'b01
`define CTX_MODE_DIV       2'b10
`define CTX_MODE_SW        2'b11
`define CTX_OP_CLEAR       2'b00
`define CTX_OP_VALUE       2'b01
`define CTX_OP_ENABLE      2'b10

// status fields and divider edge count
`define CTX_STAT_FIFO      12
`define CTX_STAT_NONGRP_LO 8
`define CTX_EDGES_PER_LATCH 8000

`endif
